/* design/synth_enable_reset_strobe_regs.sv */
/*
  enable, reset and strobe register bank of a fractional-n synthesizer,
  with the gating and reset controls that its fields drive.
  assumes a serial port decoder on clk presents one-cycle write strobes and
  read address, and that the analog and clock cells sit outside.
*/
// How it works
// - strobe bit 0 pulses reset of the programmable registers to defaults
// - strobe bit 1 pulses reset of the remaining digital logic
// - strobe bit 3 clocks the temperature sensor once
// - bias enable clear disables the whole synthesizer loop
// - reference divider enable clear holds divider in reset, same as bypass
// - bit 3 gates the muxed crystal reference into digital logic
// - bit 4 passes the divided reference clock into digital logic
// - bits 5 and 6 route square and sine crystal clocks to digital
// - square buffer needs bit 7 and sine-select low; sine needs bit 8, select high
// - bit 9 selects modulator clock: one oscillator, zero reference path
// - bit 10 turns prescaler bias on
// - bit 11 enables and un-resets digital lock detect and its gates
// - bit 12 enables the charge pump, otherwise output goes high-impedance
// - bit 13 low resets the fractional modulator
// - bit 14 low resets the lock detect circuit
// - slip prevention needs bit 15 and the phase-detector slip bit
// - force enable drives the force value onto the serial out pin
`timescale 1ns/1ps
module synth_enable_reset_strobe_regs (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [5:0] wr_addr,
  input wire logic [23:0] wr_data,
  input wire logic [5:0] rd_addr,
  output logic [23:0] rd_data,
  input wire logic serial_read_bit,
  input wire logic lock_detect_bit,
  input wire logic serial_read_active,
  input wire logic sine_select,
  input wire logic slip_phase_enable,
  input wire logic integer_mode,
  output logic regs_soft_reset,
  output logic digital_soft_reset,
  output logic temp_measure_strobe,
  output logic vco_buffer_enable,
  output logic loop_enable,
  output logic refdiv_run,
  output logic refdiv_bypass,
  output logic xref_to_digital,
  output logic divref_to_digital,
  output logic square_to_digital,
  output logic sine_to_digital,
  output logic square_buffer_enable,
  output logic sine_buffer_enable,
  output logic modulator_clock_vco,
  output logic prescaler_bias_enable,
  output logic lock_gates_enable,
  output logic pump_enable,
  output logic pump_drive_oe,
  output logic modulator_run,
  output logic modulator_fractional,
  output logic lock_detect_run,
  output logic slip_prevention,
  output logic lock_or_serial_out_pin
);

  // the fixed slices of wr_data and rd_data below assume these field widths
  if (synth_ctrl_pkg::STB_W != 4 || synth_ctrl_pkg::EN_W != 16
      || synth_ctrl_pkg::FRC_W != 2) begin : g_width_check
    $error("synth_enable_reset_strobe_regs: package field widths do not fit the ports");
  end
  // reset release through two flops
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // write decode
  logic wr_strobe;
  logic wr_enable;
  logic wr_force;
  assign wr_strobe = wr_en && (wr_addr == synth_ctrl_pkg::ADDR_STROBE);
  assign wr_enable = wr_en && (wr_addr == synth_ctrl_pkg::ADDR_ENABLE);
  assign wr_force = wr_en && (wr_addr == synth_ctrl_pkg::ADDR_FORCE);

  // strobe pulses; reserved bit 2 masked off
  logic [3:0] strobe_pulse;
  localparam logic [3:0] STROBE_KEEP = 4'hb;
  strobe_pulser #(
    .WIDTH(synth_ctrl_pkg::STB_W)
  ) u_pulser (
    .clk(clk),
    .rst_n(rst_sync_q),
    .wr_en(wr_strobe),
    .wr_bits(wr_data[3:0]),
    .keep_mask(STROBE_KEEP),
    .pulse(strobe_pulse)
  );

  // programmable registers
  logic [15:0] enable_q;
  logic [15:0] enable_d;
  logic [1:0] force_q;
  logic [1:0] force_d;

  // load on write; soft reset of registers restores defaults
  always_comb begin
    enable_d = enable_q;
    force_d = force_q;
    if (strobe_pulse[synth_ctrl_pkg::STB_REGS]) begin
      enable_d = synth_ctrl_pkg::ENABLE_RESET;
      force_d = synth_ctrl_pkg::FORCE_RESET;
    end else begin
      if (wr_enable) begin
        enable_d = wr_data[15:0];
      end
      if (wr_force) begin
        force_d = wr_data[1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      enable_q <= synth_ctrl_pkg::ENABLE_RESET;
      force_q <= synth_ctrl_pkg::FORCE_RESET;
    end else begin
      enable_q <= enable_d;
      force_q <= force_d;
    end
  end

  // strobe outputs
  assign regs_soft_reset = strobe_pulse[synth_ctrl_pkg::STB_REGS];
  assign digital_soft_reset = strobe_pulse[synth_ctrl_pkg::STB_DIG];
  assign temp_measure_strobe = strobe_pulse[synth_ctrl_pkg::STB_TEMP];

  // one enable field gated by bias enable; every loop block goes through this
  function automatic logic gated(input logic bias_on, input logic field);
    gated = bias_on && field;
  endfunction : gated

  // next values of the decoded controls
  logic bias;
  logic vco_buffer_enable_d;
  logic loop_enable_d;
  logic refdiv_run_d;
  logic refdiv_bypass_d;
  logic xref_to_digital_d;
  logic divref_to_digital_d;
  logic square_to_digital_d;
  logic sine_to_digital_d;
  logic square_buffer_enable_d;
  logic sine_buffer_enable_d;
  logic modulator_clock_vco_d;
  logic prescaler_bias_enable_d;
  logic lock_gates_enable_d;
  logic pump_enable_d;
  logic pump_drive_oe_d;
  logic modulator_run_d;
  logic modulator_fractional_d;
  logic lock_detect_run_d;
  logic slip_prevention_d;
  logic lock_or_serial_out_pin_d;
  // registered decoded controls
  logic vco_buffer_enable_q;
  logic loop_enable_q;
  logic refdiv_run_q;
  logic refdiv_bypass_q;
  logic xref_to_digital_q;
  logic divref_to_digital_q;
  logic square_to_digital_q;
  logic sine_to_digital_q;
  logic square_buffer_enable_q;
  logic sine_buffer_enable_q;
  logic modulator_clock_vco_q;
  logic prescaler_bias_enable_q;
  logic lock_gates_enable_q;
  logic pump_enable_q;
  logic pump_drive_oe_q;
  logic modulator_run_q;
  logic modulator_fractional_q;
  logic lock_detect_run_q;
  logic slip_prevention_q;
  logic lock_or_serial_out_pin_q;

  // decode; loop blocks drop with bias enable, clock select and pin do not
  always_comb begin
    bias = enable_q[synth_ctrl_pkg::EN_BIAS];
    vco_buffer_enable_d = gated(bias, enable_q[synth_ctrl_pkg::EN_VCOBUF]);
    loop_enable_d = bias;
    refdiv_run_d = gated(bias, enable_q[synth_ctrl_pkg::EN_REFDIV]);
    refdiv_bypass_d = !refdiv_run_d;
    xref_to_digital_d = gated(bias, enable_q[synth_ctrl_pkg::EN_XREF_DIG]);
    divref_to_digital_d = gated(bias, enable_q[synth_ctrl_pkg::EN_DIV_DIG]);
    square_to_digital_d = gated(bias, enable_q[synth_ctrl_pkg::EN_SQR_DIG]);
    sine_to_digital_d = gated(bias, enable_q[synth_ctrl_pkg::EN_SIN_DIG]);
    square_buffer_enable_d = gated(bias, enable_q[synth_ctrl_pkg::EN_SQ_BUF])
      && !sine_select;
    sine_buffer_enable_d = gated(bias, enable_q[synth_ctrl_pkg::EN_SIN_BUF])
      && sine_select;
    modulator_clock_vco_d = enable_q[synth_ctrl_pkg::EN_VCO_MOD];
    prescaler_bias_enable_d = gated(bias, enable_q[synth_ctrl_pkg::EN_PRESC]);
    lock_gates_enable_d = gated(bias, enable_q[synth_ctrl_pkg::EN_LKD]);
    pump_enable_d = gated(bias, enable_q[synth_ctrl_pkg::EN_PUMP]);
    pump_drive_oe_d = pump_enable_d;
    modulator_run_d = gated(bias, enable_q[synth_ctrl_pkg::EN_DSM]);
    modulator_fractional_d = modulator_run_d && !integer_mode;
    lock_detect_run_d = gated(bias, enable_q[synth_ctrl_pkg::EN_LOCK]);
    slip_prevention_d = gated(bias, enable_q[synth_ctrl_pkg::EN_SLIP])
      && slip_phase_enable;
    lock_or_serial_out_pin_d = force_q[synth_ctrl_pkg::FRC_EN]
      ? force_q[synth_ctrl_pkg::FRC_VAL]
      : (serial_read_active ? serial_read_bit : lock_detect_bit);
  end

  // every control output comes straight from a flop, low while in reset
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      vco_buffer_enable_q <= 1'b0;
      loop_enable_q <= 1'b0;
      refdiv_run_q <= 1'b0;
      refdiv_bypass_q <= 1'b0;
      xref_to_digital_q <= 1'b0;
      divref_to_digital_q <= 1'b0;
      square_to_digital_q <= 1'b0;
      sine_to_digital_q <= 1'b0;
      square_buffer_enable_q <= 1'b0;
      sine_buffer_enable_q <= 1'b0;
      modulator_clock_vco_q <= 1'b0;
      prescaler_bias_enable_q <= 1'b0;
      lock_gates_enable_q <= 1'b0;
      pump_enable_q <= 1'b0;
      pump_drive_oe_q <= 1'b0;
      modulator_run_q <= 1'b0;
      modulator_fractional_q <= 1'b0;
      lock_detect_run_q <= 1'b0;
      slip_prevention_q <= 1'b0;
      lock_or_serial_out_pin_q <= 1'b0;
    end else begin
      vco_buffer_enable_q <= vco_buffer_enable_d;
      loop_enable_q <= loop_enable_d;
      refdiv_run_q <= refdiv_run_d;
      refdiv_bypass_q <= refdiv_bypass_d;
      xref_to_digital_q <= xref_to_digital_d;
      divref_to_digital_q <= divref_to_digital_d;
      square_to_digital_q <= square_to_digital_d;
      sine_to_digital_q <= sine_to_digital_d;
      square_buffer_enable_q <= square_buffer_enable_d;
      sine_buffer_enable_q <= sine_buffer_enable_d;
      modulator_clock_vco_q <= modulator_clock_vco_d;
      prescaler_bias_enable_q <= prescaler_bias_enable_d;
      lock_gates_enable_q <= lock_gates_enable_d;
      pump_enable_q <= pump_enable_d;
      pump_drive_oe_q <= pump_drive_oe_d;
      modulator_run_q <= modulator_run_d;
      modulator_fractional_q <= modulator_fractional_d;
      lock_detect_run_q <= lock_detect_run_d;
      slip_prevention_q <= slip_prevention_d;
      lock_or_serial_out_pin_q <= lock_or_serial_out_pin_d;
    end
  end

  // control outputs
  assign vco_buffer_enable = vco_buffer_enable_q;
  assign loop_enable = loop_enable_q;
  assign refdiv_run = refdiv_run_q;
  assign refdiv_bypass = refdiv_bypass_q;
  assign xref_to_digital = xref_to_digital_q;
  assign divref_to_digital = divref_to_digital_q;
  assign square_to_digital = square_to_digital_q;
  assign sine_to_digital = sine_to_digital_q;
  assign square_buffer_enable = square_buffer_enable_q;
  assign sine_buffer_enable = sine_buffer_enable_q;
  assign modulator_clock_vco = modulator_clock_vco_q;
  assign prescaler_bias_enable = prescaler_bias_enable_q;
  assign lock_gates_enable = lock_gates_enable_q;
  assign pump_enable = pump_enable_q;
  assign pump_drive_oe = pump_drive_oe_q;
  assign modulator_run = modulator_run_q;
  assign modulator_fractional = modulator_fractional_q;
  assign lock_detect_run = lock_detect_run_q;
  assign slip_prevention = slip_prevention_q;
  assign lock_or_serial_out_pin = lock_or_serial_out_pin_q;

  // read mux; strobe address reads zero here, unmapped reads zero
  logic [23:0] rd_d;
  logic [23:0] rd_q;
  always_comb begin
    case (rd_addr)
      synth_ctrl_pkg::ADDR_ENABLE: rd_d = {8'h00, enable_q};
      synth_ctrl_pkg::ADDR_FORCE: rd_d = {22'h000000, force_q};
      default: rd_d = 24'h000000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rd_q <= 24'h000000;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign rd_data = rd_q;
endmodule : synth_enable_reset_strobe_regs

/* design/synth_ctrl_pkg.sv */
/*
  constants for the synthesizer enable, reset and strobe register bank:
  register addresses, field positions, reset values and widths.
  assumes a six-bit register address and 24-bit register data.
*/
package synth_ctrl_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 24;
  // register addresses
  localparam logic [5:0] ADDR_STROBE = 6'h00;
  localparam logic [5:0] ADDR_ENABLE = 6'h01;
  localparam logic [5:0] ADDR_FORCE = 6'h02;
  // strobe field positions
  localparam int STB_REGS = 0;
  localparam int STB_DIG = 1;
  localparam int STB_RSVD = 2;
  localparam int STB_TEMP = 3;
  localparam int STB_W = 4;
  // enable field positions
  localparam int EN_VCOBUF = 0;
  localparam int EN_BIAS = 1;
  localparam int EN_REFDIV = 2;
  localparam int EN_XREF_DIG = 3;
  localparam int EN_DIV_DIG = 4;
  localparam int EN_SQR_DIG = 5;
  localparam int EN_SIN_DIG = 6;
  localparam int EN_SQ_BUF = 7;
  localparam int EN_SIN_BUF = 8;
  localparam int EN_VCO_MOD = 9;
  localparam int EN_PRESC = 10;
  localparam int EN_LKD = 11;
  localparam int EN_PUMP = 12;
  localparam int EN_DSM = 13;
  localparam int EN_LOCK = 14;
  localparam int EN_SLIP = 15;
  localparam int EN_W = 16;
  localparam logic [15:0] ENABLE_RESET = 16'hfe9b;
  // force register fields
  localparam int FRC_VAL = 0;
  localparam int FRC_EN = 1;
  localparam int FRC_W = 2;
  localparam logic [1:0] FORCE_RESET = 2'h3;
  // soft-reset pulse length in cycles
  localparam int SOFT_RST_CYCLES = 1;
endpackage : synth_ctrl_pkg

/* design/strobe_pulser.sv */
/*
  turns a write of ones into single-cycle pulses, one per strobe bit.
  assumes wr_en is a one-cycle pulse in the clk domain.
*/
`timescale 1ns/1ps
module strobe_pulser #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_bits,
  input wire logic [WIDTH-1:0] keep_mask,
  output logic [WIDTH-1:0] pulse
);
  if (WIDTH < 1) begin : g_bad_width
    $error("strobe_pulser: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] pulse_d;
  logic [WIDTH-1:0] pulse_q;

  // one only in the cycle after the write; zeros and masked bits ignored
  always_comb begin
    pulse_d = wr_en ? (wr_bits & keep_mask) : '0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_q <= '0;
    end else begin
      pulse_q <= pulse_d;
    end
  end

  assign pulse = pulse_q;
endmodule : strobe_pulser

/* dv/regs_checker_assertions.sv */
/* checker of the enable, strobe and force register bank at its ports.
   assumes it is bound onto the top module, one clock domain. */
`timescale 1ns/1ps
module regs_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [5:0] wr_addr,
  input wire logic [23:0] wr_data,
  input wire logic regs_soft_reset,
  input wire logic digital_soft_reset,
  input wire logic temp_measure_strobe,
  input wire logic loop_enable,
  input wire logic refdiv_run,
  input wire logic refdiv_bypass,
  input wire logic pump_drive_oe,
  input wire logic square_buffer_enable,
  input wire logic sine_select,
  input wire logic slip_prevention,
  input wire logic slip_phase_enable,
  input wire logic lock_or_serial_out_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // write kinds and a following cycle free of writes and register resets
  wire logic stb_wr = wr_en && wr_addr == 6'h00;
  wire logic en_wr = wr_en && wr_addr == 6'h01 && !regs_soft_reset;
  wire logic frc_wr = wr_en && wr_addr == 6'h02 && !regs_soft_reset;
  wire logic quiet = !wr_en && !regs_soft_reset;
  regs_pulse_a:
    assert property (stb_wr |-> ##1 regs_soft_reset == $past(wr_data[0])) else $error("regs");
  dig_pulse_a:
    assert property (stb_wr |-> ##1 digital_soft_reset == $past(wr_data[1])) else $error("dig");
  temp_pulse_a:
    assert property (stb_wr |-> ##1 temp_measure_strobe == $past(wr_data[3])) else $error("tmp");
  no_pulse_a:
    assert property (!stb_wr |-> ##1 !(regs_soft_reset || digital_soft_reset
      || temp_measure_strobe)) else $error("stray strobe pulse");
  loop_gate_a:
    assert property (en_wr ##1 quiet |-> ##1 loop_enable == $past(wr_data[1], 2))
    else $error("loop enable");
  refdiv_hold_a:
    assert property (en_wr ##1 quiet |-> ##1 refdiv_bypass == !refdiv_run
      && refdiv_run == ($past(wr_data[1], 2) && $past(wr_data[2], 2))) else $error("refdiv");
  pump_tristate_a:
    assert property (en_wr ##1 quiet |-> ##1
      pump_drive_oe == ($past(wr_data[1], 2) && $past(wr_data[12], 2))) else $error("pump");
  square_sel_a:
    assert property (square_buffer_enable |-> !$past(sine_select)) else $error("square buf");
  slip_needs_a:
    assert property (slip_prevention |-> $past(slip_phase_enable)) else $error("slip");
  pin_force_a:
    assert property (frc_wr && wr_data[1] ##1 quiet |-> ##1
      lock_or_serial_out_pin == $past(wr_data[0], 2)) else $error("forced pin");
endmodule : regs_checker

bind synth_enable_reset_strobe_regs regs_checker i_regs_checker (.clk(clk), .arst_n(arst_n),
  .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .regs_soft_reset(regs_soft_reset),
  .digital_soft_reset(digital_soft_reset), .temp_measure_strobe(temp_measure_strobe),
  .loop_enable(loop_enable), .refdiv_run(refdiv_run), .refdiv_bypass(refdiv_bypass),
  .pump_drive_oe(pump_drive_oe), .square_buffer_enable(square_buffer_enable),
  .sine_select(sine_select), .slip_prevention(slip_prevention),
  .slip_phase_enable(slip_phase_enable), .lock_or_serial_out_pin(lock_or_serial_out_pin));

/* dv/host_port.sv */
/* host side of the register port: one write task and one read task.
   assumes the bench calls them; signals move at falling edges only. */
`timescale 1ns/1ps
module host_port (
  input wire logic clk,
  output logic wr_en,
  output logic [5:0] wr_addr,
  output logic [23:0] wr_data,
  output logic [5:0] rd_addr,
  input wire logic [23:0] rd_data
);
  // idle port
  initial begin
    wr_en = 1'b0;
    wr_addr = 6'h3f;
    wr_data = 24'h0;
    rd_addr = 6'h00;
  end
  // write held across one rising edge, then data scrambled
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clk);
    wr_en = 1'b0;
    wr_addr = ~a;
    wr_data = ~d;
  endtask : wr
  // address held over one edge, data taken after it
  task automatic rd(input logic [5:0] a, output logic [23:0] d);
    @(negedge clk);
    rd_addr = a;
    @(negedge clk);
    d = rd_data;
  endtask : rd
endmodule : host_port

/* dv/tb_synth_enable_reset_strobe_regs.sv */
/* self-checking bench of the register bank: defaults, strobes, random settings.
   assumes host_port as the register host and the bound checker. */
`timescale 1ns/1ps
module tb_synth_enable_reset_strobe_regs;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [5:0] ins = 6'h00; // int mode, lock, serial bit, serial active, slip, sine
  logic [23:0] got, e, f;
  wire logic wr_en;
  wire logic [5:0] wr_addr, rd_addr;
  wire logic [23:0] wr_data, rd_data;
  wire logic [2:0] stb;
  wire logic [19:0] outs;
  int n_errors = 0;
  int cmp_count = 0;
  always #10 clk = ~clk;
  host_port i_host_port (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_data));
  synth_enable_reset_strobe_regs i_synth_enable_reset_strobe_regs (.clk(clk), .arst_n(arst_n),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
    .serial_read_bit(ins[3]), .lock_detect_bit(ins[4]), .serial_read_active(ins[2]),
    .sine_select(ins[0]), .slip_phase_enable(ins[1]), .integer_mode(ins[5]),
    .regs_soft_reset(stb[0]), .digital_soft_reset(stb[1]), .temp_measure_strobe(stb[2]),
    .vco_buffer_enable(outs[0]), .loop_enable(outs[1]), .refdiv_run(outs[2]),
    .refdiv_bypass(outs[3]), .xref_to_digital(outs[4]), .divref_to_digital(outs[5]),
    .square_to_digital(outs[6]), .sine_to_digital(outs[7]), .square_buffer_enable(outs[8]),
    .sine_buffer_enable(outs[9]), .modulator_clock_vco(outs[10]),
    .prescaler_bias_enable(outs[11]), .lock_gates_enable(outs[12]), .pump_enable(outs[13]),
    .pump_drive_oe(outs[14]), .modulator_run(outs[15]), .modulator_fractional(outs[16]),
    .lock_detect_run(outs[17]), .slip_prevention(outs[18]), .lock_or_serial_out_pin(outs[19]));
  // decoded controls expected from enable word, force field and side inputs
  function automatic logic [19:0] exp_outs(logic [15:0] n, logic [1:0] c, logic [5:0] i);
    logic b;
    b = n[1];
    exp_outs = {c[1] ? c[0] : (i[2] ? i[3] : i[4]), b & n[15] & i[1], b & n[14],
      b & n[13] & !i[5], b & n[13], b & n[12], b & n[12], b & n[11], b & n[10], n[9],
      b & n[8] & i[0], b & n[7] & !i[0], b & n[6], b & n[5], b & n[4], b & n[3],
      !(b & n[2]), b & n[2], b, b & n[0]};
  endfunction : exp_outs
  // compare and count
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // verdict and end of run
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  // hang guard
  initial begin
    #1000000;
    n_errors++;
    wrap_up();
  end
  // main sequence
  initial begin
    void'($urandom(32'h26dc408f));
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    // reset values; strobe and unmapped places read zero
    for (int k = 0; k < 4; k++) begin
      i_host_port.rd(k == 3 ? 6'h3f : 6'(k), got);
      chk(got, k == 1 ? {8'h00, synth_ctrl_pkg::ENABLE_RESET} : 24'(k == 2 ? 3 : 0));
    end
    chk({4'h0, outs}, {4'h0, exp_outs(16'hfe9b, 2'h3, ins)});
    // random settings with all-off and all-on corners, plus an ignored write
    for (int k = 0; k < 30; k++) begin
      e = (k == 0) ? 24'h0 : (k == 1) ? 24'hffffff : 24'($urandom);
      f = 24'($urandom);
      ins = 6'($urandom);
      i_host_port.wr(6'h01, e);
      i_host_port.wr(6'h02, f);
      i_host_port.wr(6'h05, ~e);
      @(negedge clk);
      chk({4'h0, outs}, {4'h0, exp_outs(e[15:0], f[1:0], ins)});
      i_host_port.rd(6'h01, got);
      chk(got, {8'h00, e[15:0]});
      i_host_port.rd(6'h02, got);
      chk(got, {22'h0, f[1:0]});
    end
    // each strobe bit alone: one pulse then quiet, none for reserved bit 2; bit 0 restores defaults
    for (int k = 0; k < 4; k++) begin
      i_host_port.wr(6'h01, 24'h0);
      // the pulse stands from the write's edge to the next one
      i_host_port.wr(6'h00, 24'h1 << k);
      chk({21'h0, stb}, {21'h0, k == 3, k == 1, k == 0});
      @(negedge clk);
      chk({21'h0, stb}, 24'h0);
      i_host_port.rd(6'h01, got);
      chk(got, k == 0 ? {8'h00, synth_ctrl_pkg::ENABLE_RESET} : 24'h0);
    end
    wrap_up();
  end
endmodule : tb_synth_enable_reset_strobe_regs
